/* vxi_irq_pkg.sv */
// constants, types and register map shared by both ends of the vxi interrupter link
//
// Overview of operation
// - request drives programmed level; zero disables all
// - nothing requested unless master enable set
// - separate shared-memory and processor source enables
// - one request line; status id names source
// - acknowledge cycle clears master enable, releasing line
// - handler sets master enable again afterwards
// - pending source re-requests at once when re-enabled
// - processor writes vector, then sets pending bit
// - processor source forwarded only while enabled
// - processor pending stays until written zero
// - enabled shared-memory interrupts forwarded while master enable set and level nonzero
// - shared-memory source served before processor source
// - shared-memory acknowledge returns vector 80 hex
// - software uses user-defined vectors only
package vxi_irq_pkg;

  // link widths
  localparam int unsigned LEVEL_W   = 3;             // request level field width
  localparam int unsigned NUM_LINES = 7;             // request lines, levels 1..7
  localparam int unsigned VEC_W     = 8;             // status id width

  // fixed vector for shared-memory interrupts
  localparam logic [7:0] SM_VECTOR  = 8'h80;

  // control reset values
  localparam logic [2:0] LEVEL_RST  = 3'h0;          // level 0: interrupts off
  localparam logic [7:0] VECTOR_RST = 8'h00;

  // host controller register offsets (byte addresses)
  localparam logic [7:0] HOST_CTRL_OFS   = 8'h00;
  localparam logic [7:0] HOST_STATUS_OFS = 8'h04;
  localparam logic [7:0] HOST_VECTOR_OFS = 8'h08;

  // host control field positions
  localparam int unsigned CTRL_START_BIT  = 0;       // write 1: run an acknowledge cycle
  localparam int unsigned CTRL_MIESET_BIT = 1;       // write 1: set master enable in device
  localparam int unsigned CTRL_AUTO_BIT   = 2;       // stored: re-enable after each acknowledge

  // host status field positions
  localparam int unsigned STAT_BUSY_BIT  = 8;
  localparam int unsigned STAT_VALID_BIT = 9;
  localparam int unsigned STAT_NONE_BIT  = 10;       // start found no active line

  // host vector field positions
  localparam int unsigned VEC_LEVEL_LSB = 8;

  // ahb-lite transfer type encoding
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // device acknowledge responder states
  typedef enum logic [1:0] {
    DEV_IDLE,
    DEV_ANSWER,
    DEV_RELEASE
  } dev_state_t;

  // host acknowledge sequencer states
  typedef enum logic [1:0] {
    HST_IDLE,
    HST_WAIT,
    HST_DROP
  } hst_state_t;

endpackage

/* vxi_irq_if.sv */
// link between the interrupter end and the host interrupt handler end
`timescale 1ns/100ps
interface vxi_irq_if;
  import vxi_irq_pkg::*;

  logic [NUM_LINES-1:0] irq_req;      // one bit per level, bit 0 = level 1, high = requesting
  logic                 iack;         // acknowledge cycle in progress, level
  logic [LEVEL_W-1:0]   iack_level;   // level being acknowledged
  logic                 iack_done;    // one-cycle pulse, status_id valid
  logic [VEC_W-1:0]     status_id;    // returned vector, from a flop
  logic                 mie_set;      // one-cycle pulse, host re-enables master enable

  modport dev
  (
    output irq_req,
    output iack_done,
    output status_id,
    input  iack,
    input  iack_level,
    input  mie_set
  );

  modport hst
  (
    input  irq_req,
    input  iack_done,
    input  status_id,
    output iack,
    output iack_level,
    output mie_set
  );

endinterface

/* vxi_interrupter.sv */
// interrupter end: merges processor and shared-memory sources onto one vxi request line
`timescale 1ns/100ps
module vxi_interrupter
  import vxi_irq_pkg::*;
(
  input  wire logic         clk_i,            // 50 mhz carrier clock
  input  wire logic         srst_i,           // synchronous reset, active high
  vxi_irq_if.dev            link,             // towards the host handler
  // processor side: whole interrupt control register write
  input  wire logic         cfg_wr_i,         // one-cycle write strobe
  input  wire logic [2:0]   cfg_level_i,      // request level, 0 = off
  input  wire logic         cfg_mie_i,        // master_irq_enable
  input  wire logic         cfg_pie_i,        // processor_irq_enable
  input  wire logic         cfg_shared_mem_irq_enable_i,       // shared_mem_irq_enable
  input  wire logic [7:0]   cfg_vector_i,     // processor vector
  input  wire logic         cfg_pip_i,        // processor_irq_pending
  // shared-memory device interrupt, level
  input  wire logic         sm_irq_i,
  // processor side readback
  output logic [2:0]        level_o,
  output logic              mie_o,
  output logic              pie_o,
  output logic              shared_mem_irq_enable_o,
  output logic [7:0]        vector_o,
  output logic              pip_o,
  output logic              req_active_o,     // request line currently driven
  output logic              acked_o           // one-cycle pulse per answered acknowledge
);

  ////////////////////////////////////////////////////////////////////////////////
  // control register
  //
  // the processor writes the whole control word in one strobe; only the master
  // enable has other writers (acknowledge clear and host re-enable), so it lives
  // in a process of its own with a fixed priority

  logic [2:0]  level_ff;                      // programmed request level
  logic        mie_ff;                        // master_irq_enable
  logic        pie_ff;                        // processor_irq_enable
  logic        shared_mem_irq_enable_ff;                       // shared_mem_irq_enable
  logic [7:0]  vector_ff;                     // processor vector field
  logic        pip_ff;                        // processor_irq_pending
  logic        ack_clr;                       // acknowledge clears master enable

  // level, source enables and vector are processor owned
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      level_ff  <= LEVEL_RST;
      pie_ff    <= 1'b0;
      shared_mem_irq_enable_ff   <= 1'b0;
      vector_ff <= VECTOR_RST;
    end
    else if (cfg_wr_i)
    begin
      level_ff  <= cfg_level_i;
      pie_ff    <= cfg_pie_i;
      shared_mem_irq_enable_ff   <= cfg_shared_mem_irq_enable_i;
      vector_ff <= cfg_vector_i;
    end
  end

  // pending bit leaves only when the processor writes 0
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      pip_ff <= 1'b0;
    else if (cfg_wr_i)
      pip_ff <= cfg_pip_i;
  end

  // master enable: three writers; the host's set wins so a re-enable is never lost
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      mie_ff <= 1'b0;
    else if (link.mie_set)
      mie_ff <= 1'b1;
    else if (ack_clr)
      mie_ff <= 1'b0;
    else if (cfg_wr_i)
      mie_ff <= cfg_mie_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // request merging
  //
  // both sources share one line, so the host learns the cause only from the
  // returned vector; the line is combinational so that a re-enable with a
  // source still pending raises a fresh request in the same cycle
  // limitation: the shared-memory source is a level and is cleared at its origin

  // a level of zero switches the interrupter off, for requests and answers alike
  function automatic logic level_on(input logic [2:0] lvl);
    return (lvl != 3'h0);
  endfunction

  logic sm_active;                            // shared-memory source enabled and asserting
  logic cpu_active;                           // processor source enabled and pending
  logic req_active;                           // request line wanted

  // one request built from both sources; combinational so a re-enable shows at once
  always_comb
  begin
    sm_active  = shared_mem_irq_enable_ff & sm_irq_i;
    cpu_active = pie_ff & pip_ff;
    // master enable and a nonzero level gate everything
    req_active = mie_ff & level_on(level_ff) & (sm_active | cpu_active);
  end

  // one-hot line drive: bit n-1 carries level n, all sources share it
  always_comb
  begin
    link.irq_req = '0;
    if (req_active)
      link.irq_req[level_ff - 3'h1] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // acknowledge responder
  //
  // idle -> answer -> release; the acknowledge is taken at the first edge with
  // iack high at our level, which also clears the master enable; the vector is
  // chosen at that same edge and the answer strobe is set at that edge too
  // release waits for the host to drop iack, so a long-held acknowledge cannot
  // be answered twice
  // hazard: a request that drops between the host's choice and our taking edge
  // is still answered, with whatever vector the sources select at that moment

  dev_state_t  state_ff;                      // responder state
  dev_state_t  nxt_state;
  logic [7:0]  status_id_ff;                  // returned vector
  logic        done_ff;                       // answer strobe
  logic        our_iack;                      // acknowledge aimed at our level

  // only answer for our own level; other interrupters may share the bus
  assign our_iack = link.iack & (link.iack_level == level_ff) & level_on(level_ff);

  // next state
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      DEV_IDLE:
        if (our_iack)
          nxt_state = DEV_ANSWER;
      DEV_ANSWER:
        nxt_state = DEV_RELEASE;               // answer lasts one cycle
      DEV_RELEASE:
        if (!link.iack)
          nxt_state = DEV_IDLE;               // wait for host to end the cycle
      default:
        nxt_state = DEV_IDLE;
    endcase
  end

  // master enable drops as the acknowledge is taken
  assign ack_clr = (state_ff == DEV_IDLE) & our_iack;

  // state register
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      state_ff <= DEV_IDLE;
    else
      state_ff <= nxt_state;
  end

  // vector capture: shared memory first, then the processor's field
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      status_id_ff <= 8'h00;
    else if (ack_clr)
    begin
      if (sm_active)
        status_id_ff <= SM_VECTOR;
      else
        status_id_ff <= vector_ff;
    end
  end

  // answer strobe, one cycle, aligned with the captured vector
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      done_ff <= 1'b0;
    else
      done_ff <= ack_clr;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  //
  // every data output below is a flop; only the request line and req_active_o are combinational
  // acked_o repeats the answer strobe for the processor side

  assign link.iack_done = done_ff;
  assign link.status_id = status_id_ff;
  assign level_o        = level_ff;
  assign mie_o          = mie_ff;
  assign pie_o          = pie_ff;
  assign shared_mem_irq_enable_o         = shared_mem_irq_enable_ff;
  assign vector_o       = vector_ff;
  assign pip_o          = pip_ff;
  assign req_active_o   = req_active;
  assign acked_o        = done_ff;

endmodule

/* vxi_irq_handler.sv */
// host end: interrupt handler driven by software over an ahb-lite register slave
`timescale 1ns/100ps
module vxi_irq_handler
  import vxi_irq_pkg::*;
(
  input  wire logic         clk_i,            // 50 mhz clock
  input  wire logic         srst_i,           // synchronous reset, active high
  vxi_irq_if.hst            link,             // towards the interrupter
  // ahb-lite slave
  input  wire logic         hsel_i,
  input  wire logic [7:0]   haddr_i,
  input  wire logic [1:0]   htrans_i,
  input  wire logic         hwrite_i,
  input  wire logic [2:0]   hsize_i,
  input  wire logic [31:0]  hwdata_i,
  input  wire logic         hready_i,
  output logic              hreadyout_o,
  output logic              hresp_o,
  output logic [31:0]       hrdata_o
);

  // highest requesting level, 0 when the lines are quiet
  function automatic logic [2:0] top_level(input logic [6:0] lines);
    logic [2:0] lvl;
    lvl = 3'h0;
    for (int i = 0; i < 7; i++)
      if (lines[i])
        lvl = 3'(i + 1);
    return lvl;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states

  logic        wr_pend_ff;                    // write data phase follows
  logic [7:0]  wr_addr_ff;                    // its address
  logic [31:0] rdata_ff;                      // read data, loaded in address phase
  logic        addr_ok;                       // valid address phase
  logic        wr_ctrl;                       // control written this cycle
  logic        auto_ff;                       // auto re-enable after acknowledge
  logic        valid_ff;                      // a vector has been captured
  logic        none_ff;                       // last start found no request
  logic [7:0]  vec_ff;                        // last status id
  logic [2:0]  vlev_ff;                       // level it came from
  hst_state_t  state_ff;                      // acknowledge sequencer
  logic [31:0] status_word;
  logic [31:0] vector_word;

  assign addr_ok = hsel_i & hready_i & (htrans_i == HTRANS_NONSEQ);
  assign wr_ctrl = wr_pend_ff & (wr_addr_ff == HOST_CTRL_OFS);

  // hsize unused: only whole words are carried
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end
    else
    begin
      wr_pend_ff <= addr_ok & hwrite_i;
      wr_addr_ff <= haddr_i;
    end
  end

  // readback words
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[6:0] = link.irq_req;
    status_word[STAT_BUSY_BIT]  = (state_ff != HST_IDLE);
    status_word[STAT_VALID_BIT] = valid_ff;
    status_word[STAT_NONE_BIT]  = none_ff;
    vector_word = 32'h0000_0000;
    vector_word[7:0] = vec_ff;
    vector_word[VEC_LEVEL_LSB +: 3] = vlev_ff;
  end

  // read data registered from the address phase; unmapped reads give zero
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      rdata_ff <= 32'h0000_0000;
    else if (addr_ok & ~hwrite_i)
    begin
      case (haddr_i)
        HOST_CTRL_OFS:   rdata_ff <= {29'h0, auto_ff, 2'h0};
        HOST_STATUS_OFS: rdata_ff <= status_word;
        HOST_VECTOR_OFS: rdata_ff <= vector_word;
        default:         rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // acknowledge sequencer

  logic [2:0] lvl_ff;                         // level under acknowledge
  logic       iack_ff;
  logic       mieset_ff;
  logic       start;

  assign start = wr_ctrl & hwdata_i[CTRL_START_BIT] & (state_ff == HST_IDLE);

  // auto mode bit
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      auto_ff <= 1'b0;
    else if (wr_ctrl)
      auto_ff <= hwdata_i[CTRL_AUTO_BIT];
  end

  // acknowledge the top level, hold until answered, then release
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_ff <= HST_IDLE;
      iack_ff  <= 1'b0;
      lvl_ff   <= 3'h0;
      none_ff  <= 1'b0;
    end
    else
    begin
      case (state_ff)
        HST_IDLE:
          if (start)
          begin
            if (top_level(link.irq_req) != 3'h0)
            begin
              lvl_ff   <= top_level(link.irq_req);
              iack_ff  <= 1'b1;
              none_ff  <= 1'b0;
              state_ff <= HST_WAIT;
            end
            else
              none_ff <= 1'b1;                // nothing to acknowledge
          end
        HST_WAIT:
          if (link.iack_done)
          begin
            iack_ff  <= 1'b0;
            state_ff <= HST_DROP;
          end
        HST_DROP:
          state_ff <= HST_IDLE;               // one idle cycle between cycles
        default:
          state_ff <= HST_IDLE;
      endcase
    end
  end

  // captured vector; source identified only from it
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      vec_ff   <= 8'h00;
      vlev_ff  <= 3'h0;
      valid_ff <= 1'b0;
    end
    else if ((state_ff == HST_WAIT) & link.iack_done)
    begin
      vec_ff   <= link.status_id;
      vlev_ff  <= lvl_ff;
      valid_ff <= 1'b1;
    end
  end

  // re-enable: by software write, or automatically once serviced
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      mieset_ff <= 1'b0;
    else
      mieset_ff <= (wr_ctrl & hwdata_i[CTRL_MIESET_BIT])
                 | (auto_ff & (state_ff == HST_WAIT) & link.iack_done);
  end

  assign link.iack       = iack_ff;
  assign link.iack_level = lvl_ff;
  assign link.mie_set    = mieset_ff;

endmodule

/* vxi_irq_properties.sv */
// interface checker for the vxi interrupter link
`timescale 1ns/100ps
module vxi_irq_properties
  import vxi_irq_pkg::*;
(
  input wire logic                 clk_i,
  input wire logic                 srst_i,
  input wire logic [NUM_LINES-1:0] irq_req,
  input wire logic                 iack,
  input wire logic [LEVEL_W-1:0]   iack_level,
  input wire logic                 iack_done,
  input wire logic [VEC_W-1:0]     status_id,
  input wire logic                 mie_set
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////////////////////////////////////////////
  // acknowledge steps: host starts, device answers one edge on, host drops
  sequence s_start;
    $rose(iack);
  endsequence
  sequence s_answer;
    ##1 iack_done ##1 !iack;
  endsequence
  a_one_line: assert property ($onehot0(irq_req))
    else $error("more than one request line active");
  a_ack_answer: assert property (s_start |-> s_answer)
    else $error("acknowledge cycle not answered in time");
  a_done_cause: assert property (iack_done |-> $past(iack) && iack_level != 3'h0)
    else $error("answer without acknowledge at a live level");
  a_level_match: assert property (iack_done |-> $past(irq_req[iack_level - 3'h1]))
    else $error("acknowledged level was not the requested line");
  a_release_ack: assert property (iack_done && !mie_set |-> irq_req == 7'h0)
    else $error("request line not released by acknowledge");
  a_done_pulse: assert property (iack_done |=> !iack_done)
    else $error("answer pulse longer than one cycle");
  a_id_stable: assert property (!iack && !iack_done |-> $stable(status_id))
    else $error("status id changed outside acknowledge");
  a_iack_hold: assert property (iack && !iack_done |=> iack && $stable(iack_level))
    else $error("acknowledge dropped before answer");
endmodule

/* vxi_interrupt_requester_tb.sv */
// self-checking bench for the interrupter and host handler pair
`timescale 1ns/100ps
module vxi_interrupt_requester_tb;
  import vxi_irq_pkg::*;
  logic        clk_i = 1'b0;       // 50 mhz
  logic        srst_i = 1'b1;      // held two cycles
  logic        cfg_wr_i = 1'b0;    // processor write strobe
  logic [2:0]  cfg_level_i = 3'h0;
  logic        cfg_mie_i = 1'b0;
  logic        cfg_pie_i = 1'b0;
  logic        cfg_shared_mem_irq_enable_i = 1'b0;
  logic [7:0]  cfg_vector_i = 8'h00;
  logic        cfg_pip_i = 1'b0;
  logic        sm_irq_i = 1'b0;    // shared-memory source, level
  logic [2:0]  level_o;
  logic        mie_o;
  logic        pie_o;
  logic        shared_mem_irq_enable_o;
  logic [7:0]  vector_o;
  logic        pip_o;
  logic        req_active_o;
  logic        acked_o;
  logic        hsel_i = 1'b0;      // ahb master side
  logic [7:0]  haddr_i = 8'h00;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'b0;
  logic [2:0]  hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  wire         hready_i;
  logic        hreadyout_o;
  logic        hresp_o;
  logic [31:0] hrdata_o;
  logic [31:0] rdata;              // last read word
  int          errors = 0;
  int          num_checks = 0;
  int          seed = 32'heb286b36;
  int          m_level;            // model of the control register
  int          m_vec;
  bit          m_mie, m_pie, m_shared_mem_irq_enable, m_pip, m_sm;
  ////////////////////////////////////////////////////////////////////////////////
  // the pair under test, joined by the link
  vxi_irq_if link ();
  vxi_interrupter u_vxi_interrupter (.clk_i(clk_i), .srst_i(srst_i), .link(link), .cfg_wr_i(cfg_wr_i),
    .cfg_level_i(cfg_level_i), .cfg_mie_i(cfg_mie_i), .cfg_pie_i(cfg_pie_i), .cfg_shared_mem_irq_enable_i(cfg_shared_mem_irq_enable_i),
    .cfg_vector_i(cfg_vector_i), .cfg_pip_i(cfg_pip_i), .sm_irq_i(sm_irq_i), .level_o(level_o),
    .mie_o(mie_o), .pie_o(pie_o), .shared_mem_irq_enable_o(shared_mem_irq_enable_o), .vector_o(vector_o), .pip_o(pip_o),
    .req_active_o(req_active_o), .acked_o(acked_o));
  vxi_irq_handler u_vxi_irq_handler (.clk_i(clk_i), .srst_i(srst_i), .link(link), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o));
  vxi_irq_properties u_props (.clk_i(clk_i), .srst_i(srst_i), .irq_req(link.irq_req), .iack(link.iack),
    .iack_level(link.iack_level), .iack_done(link.iack_done), .status_id(link.status_id),
    .mie_set(link.mie_set));
  assign hready_i = hreadyout_o;   // single slave drives the bus ready
  always #10 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  // expected request lines from the model
  function automatic logic [6:0] exp_req();
    exp_req = 7'h0;
    if (m_mie && m_level != 0 && ((m_shared_mem_irq_enable && m_sm) || (m_pie && m_pip)))
      exp_req[m_level-1] = 1'b1;
  endfunction
  // word compare, counted
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // request lines, activity flag and register readback
  task chk_line();
    #1;
    chk_word({25'h0, link.irq_req}, {25'h0, exp_req()});
    chk_word({31'h0, req_active_o}, {31'h0, |exp_req()});
    chk_word({17'h0, level_o, mie_o, pie_o, shared_mem_irq_enable_o, vector_o, pip_o},
             {17'h0, m_level[2:0], m_mie, m_pie, m_shared_mem_irq_enable, m_vec[7:0], m_pip});
  endtask
  // one single ahb transfer; waits on ready, data taken at the last edge
  task ahb(input bit wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    haddr_i <= a;
    htrans_i <= HTRANS_NONSEQ;
    hwrite_i <= wr;
    hsize_i <= 3'h2;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    htrans_i <= HTRANS_IDLE;
    hsel_i <= 1'b0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    rdata = hrdata_o;
    chk_word({31'h0, hresp_o}, 32'h0);
  endtask
  // whole control register write from the processor side, random vector
  task cfg(input int lv, input bit master_irq_enable, input bit processor_irq_enable, input bit shared_mem_irq_enable, input bit processor_irq_pending);
    m_level = lv;
    m_mie = master_irq_enable;
    m_pie = processor_irq_enable;
    m_shared_mem_irq_enable = shared_mem_irq_enable;
    m_pip = processor_irq_pending;
    m_vec = $random(seed) & 32'hff;
    @(posedge clk_i);
    cfg_wr_i <= 1'b1;
    cfg_level_i <= lv[2:0];
    cfg_mie_i <= master_irq_enable;
    cfg_pie_i <= processor_irq_enable;
    cfg_shared_mem_irq_enable_i <= shared_mem_irq_enable;
    cfg_vector_i <= m_vec[7:0];
    cfg_pip_i <= processor_irq_pending;
    sm_irq_i <= m_sm;
    @(posedge clk_i);
    cfg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // host acknowledge cycle, optionally re-enabling afterwards
  task ack(input bit auto_on);
    logic [7:0] ev;
    ev = (m_shared_mem_irq_enable && m_sm) ? SM_VECTOR : m_vec[7:0];
    ahb(1'b1, HOST_CTRL_OFS, {29'h0, auto_on, 2'h1});
    m_mie = 1'b0;
    for (int i = 0; i < 20 && link.iack_done !== 1'b1; i++)
    begin
      @(posedge clk_i);
      #1;
    end
    chk_word({24'h0, link.status_id}, {24'h0, ev});
    chk_word({31'h0, acked_o}, 32'h1);
    chk_word({25'h0, link.irq_req}, 32'h0);
    ahb(1'b0, HOST_VECTOR_OFS, 32'h0);
    chk_word(rdata & 32'h7ff, {21'h0, m_level[2:0], ev});
    m_mie = auto_on;
  endtask
  task end_sim();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    ahb(1'b0, HOST_STATUS_OFS, 32'h0);
    chk_word(rdata, 32'h0);
    for (int lv = 0; lv < 8; lv++)
    begin
      cfg(lv, 1'b1, 1'b1, 1'b0, 1'b1);
      chk_line();
    end
    // every mix of master, source enables and pending sources
    for (int k = 0; k < 32; k++)
    begin
      m_sm = k[4];
      cfg(5, k[0], k[1], k[2], k[3]);
      chk_line();
    end
    m_sm = 1'b1;
    cfg(3, 1'b1, 1'b1, 1'b1, 1'b1);
    ack(1'b0);
    chk_line();
    ahb(1'b1, HOST_CTRL_OFS, 32'h2);
    m_mie = 1'b1;
    repeat (3) @(posedge clk_i);
    chk_line();
    ahb(1'b0, HOST_STATUS_OFS, 32'h0);
    chk_word(rdata & 32'h7f, {25'h0, exp_req()});
    m_sm = 1'b0;
    cfg(3, 1'b1, 1'b1, 1'b1, 1'b1);
    ack(1'b1);
    chk_line();
    cfg(3, 1'b1, 1'b1, 1'b1, 1'b0);
    chk_line();
    m_sm = 1'b1;
    cfg(7, 1'b1, 1'b0, 1'b1, 1'b0);
    ack(1'b1);
    chk_line();
    // auto bit reads back; a start with quiet lines finds nothing to acknowledge
    ahb(1'b0, HOST_CTRL_OFS, 32'h0);
    chk_word(rdata, 32'h1 << CTRL_AUTO_BIT);
    cfg(7, 1'b1, 1'b1, 1'b0, 1'b0);
    chk_line();
    ahb(1'b1, HOST_CTRL_OFS, 32'h1);
    ahb(1'b0, HOST_STATUS_OFS, 32'h0);
    chk_word(rdata, (32'h1 << STAT_NONE_BIT) | (32'h1 << STAT_VALID_BIT));
    // unmapped place: write ignored, read gives zero
    ahb(1'b1, 8'h0c, $random(seed));
    ahb(1'b0, 8'h0c, 32'h0);
    chk_word(rdata, 32'h0);
    end_sim();
  end
  // watchdog against a hang
  initial
  begin
    #200000;
    errors++;
    end_sim();
  end
endmodule
